/* lph_pkg.sv */
/*
  Package for the link primitive exchange block: register offsets, field
  positions, reset values, command and event codes, link phases and the
  packed structs that carry events and commands.
  Assumes nothing of its surroundings; every design file imports it whole.
*/
package lph_pkg;

  // Word offsets on the register port.
  localparam logic [3:0] LPH_OFS_PRIM = 4'h0;
  localparam logic [3:0] LPH_OFS_CTRL = 4'h1;
  localparam logic [3:0] LPH_OFS_STAT = 4'h2;

  // Field positions of the primitive exchange register.
  localparam int LPH_CONFLICT_BIT = 15;
  localparam int LPH_CMD_PEND_BIT = 14;
  localparam int LPH_CMD_HI = 11;
  localparam int LPH_CMD_LO = 8;
  localparam int LPH_DROP_BIT = 7;
  localparam int LPH_EV_PEND_BIT = 6;
  localparam int LPH_REASON_HI = 5;
  localparam int LPH_REASON_LO = 4;
  localparam int LPH_EV_HI = 3;
  localparam int LPH_EV_LO = 0;

  // Field positions of the control register.
  localparam int LPH_IRQ_EN_BIT = 0;
  localparam int LPH_BYPASS_BIT = 1;
  localparam int LPH_UPDATE_BIT = 3;

  // Field positions of the read-only state register.
  localparam int LPH_INIT_BIT = 3;
  localparam int LPH_CONN_IND_BIT = 4;
  localparam int LPH_RST_IND_BIT = 5;
  localparam int LPH_XID_IND_BIT = 6;
  localparam int LPH_TEST_IND_BIT = 7;

  localparam logic [15:0] LPH_RDATA_RST = 16'h0000;
  localparam logic [3:0] LPH_CODE_RST = 4'h0;
  localparam logic [1:0] LPH_REASON_RST = 2'h0;

  // Host command codes.
  typedef enum logic [3:0] {
    LPH_CMD_STOP = 4'h0,
    LPH_CMD_START = 4'h1,
    LPH_CMD_INIT = 4'h2,
    LPH_CMD_TRANSP = 4'h3,
    LPH_CMD_STATUS = 4'h4,
    LPH_CMD_CONN_REQ = 4'h6,
    LPH_CMD_CONN_RSP = 4'h7,
    LPH_CMD_RST_REQ = 4'h8,
    LPH_CMD_RST_RSP = 4'h9,
    LPH_CMD_XID_REQ = 4'hA,
    LPH_CMD_XID_RSP = 4'hB,
    LPH_CMD_TEST_REQ = 4'hC,
    LPH_CMD_TEST_RSP = 4'hD,
    LPH_CMD_DISC_REQ = 4'hE
  } lph_cmd_t;

  // Provider event codes.
  localparam logic [3:0] LPH_EV_INIT_DONE = 4'h2;
  localparam logic [3:0] LPH_EV_ERROR = 4'h4;
  localparam logic [3:0] LPH_EV_CONN_IND = 4'h6;
  localparam logic [3:0] LPH_EV_CONN_CNF = 4'h7;
  localparam logic [3:0] LPH_EV_RST_IND = 4'h8;
  localparam logic [3:0] LPH_EV_RST_CNF = 4'h9;
  localparam logic [3:0] LPH_EV_XID_IND = 4'hA;
  localparam logic [3:0] LPH_EV_XID_CNF = 4'hB;
  localparam logic [3:0] LPH_EV_TEST_IND = 4'hC;
  localparam logic [3:0] LPH_EV_TEST_CNF = 4'hD;
  localparam logic [3:0] LPH_EV_DISC_IND = 4'hE;

  // Link phases.
  typedef enum logic [2:0] {
    LPH_PH_STOPPED = 3'b000,
    LPH_PH_DISC = 3'b001,
    LPH_PH_CONNECTING = 3'b010,
    LPH_PH_LINKED = 3'b011,
    LPH_PH_RESETTING = 3'b100,
    LPH_PH_TRANSP = 3'b101
  } lph_phase_t;

  // Indications received and not yet answered, and whether an init command was carried out.
  typedef struct packed {
    logic init_done;
    logic conn_ind;
    logic rst_ind;
    logic xid_ind;
    logic test_ind;
  } lph_ind_t;

  localparam lph_ind_t LPH_IND_RST = '{default: 1'b0};

  // Provider event posted by the protocol engine.
  typedef struct packed {
    logic valid;
    logic [3:0] code;
    logic [1:0] reason;
  } lph_event_t;

  // Accepted command handed to the protocol engine.
  typedef struct packed {
    logic valid;
    logic [3:0] code;
    logic send_dm;
  } lph_cmd_out_t;

  localparam lph_cmd_out_t LPH_CMD_OUT_RST = '{default: 1'b0};

endpackage

/* lph_sticky_flag.sv */
/*
  Sticky flag: set by a hardware event, cleared by a separate request.
  Assumes one clock and a synchronous active-high reset.
*/
`timescale 1ns/1ns
module lph_sticky_flag
  import lph_pkg::*;
(
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic set_i,
  input wire logic clr_i,
  output logic flag_o
);

  typedef struct packed {
    logic flag;
  } lph_flag_state_t;

  lph_flag_state_t state_ff;
  lph_flag_state_t nxt_state;

  // A set in the same cycle as a clear wins, so no event is lost.
  always_comb
  begin
    nxt_state.flag = set_i | (state_ff.flag & ~clr_i);
  end

  // Register the flag.
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      state_ff <= '0;
    end
    else
    begin
      state_ff <= nxt_state;
    end
  end

  assign flag_o = state_ff.flag;

endmodule // lph_sticky_flag

/* lph_cmd_check.sv */
/*
  Command legality check: decides whether a host command fits the present
  link phase and the indications that have been received.
  Purely combinational; the caller registers every effect.
*/
`timescale 1ns/1ns
module lph_cmd_check
  import lph_pkg::*;
(
  input wire logic [3:0] code_i,
  input wire lph_phase_t phase_i,
  input wire lph_ind_t ind_i,
  output logic legal_o
);

  logic stopped;
  logic disc;
  logic transp;

  assign stopped = (phase_i == LPH_PH_STOPPED);
  assign disc = (phase_i == LPH_PH_DISC);
  assign transp = (phase_i == LPH_PH_TRANSP);

  // Transparent operation is left only by a stop, so other link commands except status (code 4) are refused there.
  always_comb
  begin
    case (code_i)
      LPH_CMD_STOP: legal_o = 1'b1; // RULE_04
      LPH_CMD_START: legal_o = stopped; // RULE_05
      LPH_CMD_INIT: legal_o = stopped | disc; // RULE_06
      LPH_CMD_TRANSP: legal_o = stopped | disc; // RULE_07
      LPH_CMD_STATUS: legal_o = ind_i.init_done; // RULE_08
      LPH_CMD_CONN_REQ: legal_o = disc; // RULE_09
      LPH_CMD_CONN_RSP: legal_o = disc & ind_i.conn_ind; // RULE_09
      LPH_CMD_RST_REQ: legal_o = ~stopped & ~disc & ~transp; // RULE_10
      LPH_CMD_RST_RSP: legal_o = ind_i.rst_ind & ~transp; // RULE_10
      LPH_CMD_XID_REQ: legal_o = ~stopped & ~transp; // RULE_11
      LPH_CMD_XID_RSP: legal_o = ind_i.xid_ind & ~transp; // RULE_11
      LPH_CMD_TEST_REQ: legal_o = ~stopped & ~transp; // RULE_12
      LPH_CMD_TEST_RSP: legal_o = ind_i.test_ind & ~transp; // RULE_12
      LPH_CMD_DISC_REQ: legal_o = ~stopped & ~transp; // RULE_13
      default: legal_o = 1'b0; // RULE_22
    endcase
  end

endmodule // lph_cmd_check

/* lph_link_primitive_handshake.sv */
/*
  Primitive exchange register of a link-level controller. The host posts a
  4-bit command with a pending flag; the block checks it against the link
  phase, hands accepted commands to the protocol engine and posts provider
  events with a reason, a pending flag and a lost flag.
  Assumes a protocol engine that presents provider events as one-cycle
  pulses and carries out the commands it is handed, and a host on a plain
  register port with read data one cycle after the read strobe.
*/
// Summary of operation
// RULE_01 - Conflicting host command sets conflict flag; write one clears; reset clears.
// RULE_02 - Host sets command pending after the code; block clears it once processed.
// RULE_03 - Host writes zeros into bits 13 and 12.
// RULE_04 - Code 0 stops: link idle, stopped shown, transmit ones, DMA halted.
// RULE_05 - Code 1 only when stopped: go disconnected, reset rings, send flags.
// RULE_06 - Code 2 reads init block, only when stopped or disconnected.
// RULE_07 - Code 3 enters transparent mode; filter bypass honoured; only stop leaves.
// RULE_08 - Code 4 writes link status, valid only after an init command.
// RULE_09 - Code 6 connects from disconnected; code 7 answers a connect indication.
// RULE_10 - Code 8 resets a live link; code 9 answers a reset indication.
// RULE_11 - Codes 10 and 11 send identification command and response.
// RULE_12 - Codes 12 and 13 send test command and response.
// RULE_13 - Code 14 disconnects; when already disconnected send DM with final clear.
// RULE_14 - Event lost flag sets when pending still set; clears with pending.
// RULE_15 - Posting an event sets event pending; write one or reset clears it.
// RULE_16 - Reason field accompanies disconnect, reset and error events.
// RULE_17 - Events 2, 4, 6, 7 reported; 7 means link established.
// RULE_18 - Events 8 to 13 reported; 9 means link reset done.
// RULE_19 - Event 14 reports disconnect; block is already disconnected then.
// RULE_20 - Host answers errors and indications with reset, response or disconnect.
// RULE_21 - Every register update sets the update flag, which drives the interrupt; a lost event sets the lost flag without setting the update flag.
// RULE_22 - Unlisted command codes raise the conflict flag and change nothing.
`timescale 1ns/1ns
module lph_link_primitive_handshake
  import lph_pkg::*;
(
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic [3:0] reg_addr_i,
  input wire logic [15:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [15:0] reg_rdata_o,
  input wire lph_event_t event_i,
  output lph_cmd_out_t cmd_o,
  output logic ring_reset_o,
  output logic stopped_o,
  output logic tx_mark_o,
  output logic tx_flags_o,
  output logic dma_halt_o,
  output logic transparent_o,
  output logic address_filter_bypass_o,
  output logic irq_o
);

  // State of the block in one record, apart from the conflict, event pending and update flags.
  typedef struct packed {
    lph_phase_t phase;
    lph_ind_t ind;
    logic [3:0] user_cmd_code;
    logic user_cmd_pending;
    logic [3:0] provider_event_code;
    logic [1:0] provider_event_reason;
    logic provider_event_dropped;
    logic irq_output_enable;
    logic address_filter_bypass;
    logic [15:0] rdata;
    lph_cmd_out_t cmd;
    logic ring_reset;
    logic stopped;
    logic tx_mark;
    logic tx_flags;
    logic dma_halt;
    logic transparent;
    logic irq;
  } lph_state_t;

  localparam lph_state_t LPH_STATE_RST = '{
    phase: LPH_PH_STOPPED,
    ind: LPH_IND_RST,
    user_cmd_code: LPH_CODE_RST,
    user_cmd_pending: 1'b0,
    provider_event_code: LPH_CODE_RST,
    provider_event_reason: LPH_REASON_RST,
    provider_event_dropped: 1'b0,
    irq_output_enable: 1'b0,
    address_filter_bypass: 1'b0,
    rdata: LPH_RDATA_RST,
    cmd: LPH_CMD_OUT_RST,
    ring_reset: 1'b0,
    stopped: 1'b1,
    tx_mark: 1'b1,
    tx_flags: 1'b0,
    dma_halt: 1'b1,
    transparent: 1'b0,
    irq: 1'b0
  };

  lph_state_t state_ff;
  lph_state_t nxt_state;

  logic wr_prim;
  logic wr_ctrl;
  logic cmd_legal;
  logic process_cmd;
  logic conflict_set;
  logic conflict_clr;
  logic conflict_flag;
  logic ev_pend_clr;
  logic ev_pend_flag;
  logic update_set;
  logic update_clr;
  logic update_flag;
  logic ev_post;
  logic [15:0] prim_word;
  logic [15:0] ctrl_word;
  logic [15:0] stat_word;

  assign wr_prim = reg_wr_i & (reg_addr_i == LPH_OFS_PRIM);
  assign wr_ctrl = reg_wr_i & (reg_addr_i == LPH_OFS_CTRL);

  // A pending command is taken one cycle after the host raised the flag.
  assign process_cmd = state_ff.user_cmd_pending; // RULE_02

  lph_cmd_check u_cmd_check (
    .code_i(state_ff.user_cmd_code),
    .phase_i(state_ff.phase),
    .ind_i(state_ff.ind),
    .legal_o(cmd_legal)
  );

  // Conflict flag: set by a refused command, cleared by writing one.
  assign conflict_set = process_cmd & ~cmd_legal; // RULE_01 RULE_22
  assign conflict_clr = wr_prim & reg_wdata_i[LPH_CONFLICT_BIT]; // RULE_01

  lph_sticky_flag u_conflict_flag (
    .clk_i(clk_i),
    .srst_i(srst_i),
    .set_i(conflict_set),
    .clr_i(conflict_clr),
    .flag_o(conflict_flag)
  );

  // Event pending flag: set by every event post, cleared by writing one.
  assign ev_pend_clr = wr_prim & reg_wdata_i[LPH_EV_PEND_BIT]; // RULE_15
  assign ev_post = event_i.valid & (~ev_pend_flag | ev_pend_clr); // RULE_14

  lph_sticky_flag u_event_pending (
    .clk_i(clk_i),
    .srst_i(srst_i),
    .set_i(ev_post),
    .clr_i(ev_pend_clr),
    .flag_o(ev_pend_flag)
  );

  // Update flag: set by every event post and every processed command.
  assign update_set = ev_post | process_cmd; // RULE_21
  assign update_clr = wr_ctrl & reg_wdata_i[LPH_UPDATE_BIT];

  lph_sticky_flag u_update_flag (
    .clk_i(clk_i),
    .srst_i(srst_i),
    .set_i(update_set),
    .clr_i(update_clr),
    .flag_o(update_flag)
  );

  // Read views; bits 13 and 12 and all unlisted bits read as zero.
  always_comb
  begin
    prim_word = '0;
    prim_word[LPH_CONFLICT_BIT] = conflict_flag;
    prim_word[LPH_CMD_PEND_BIT] = state_ff.user_cmd_pending;
    prim_word[LPH_CMD_HI:LPH_CMD_LO] = state_ff.user_cmd_code;
    prim_word[LPH_DROP_BIT] = state_ff.provider_event_dropped;
    prim_word[LPH_EV_PEND_BIT] = ev_pend_flag;
    prim_word[LPH_REASON_HI:LPH_REASON_LO] = state_ff.provider_event_reason;
    prim_word[LPH_EV_HI:LPH_EV_LO] = state_ff.provider_event_code;
    ctrl_word = '0;
    ctrl_word[LPH_IRQ_EN_BIT] = state_ff.irq_output_enable;
    ctrl_word[LPH_BYPASS_BIT] = state_ff.address_filter_bypass;
    ctrl_word[LPH_UPDATE_BIT] = update_flag;
    stat_word = '0;
    stat_word[2:0] = state_ff.phase;
    stat_word[LPH_INIT_BIT] = state_ff.ind.init_done;
    stat_word[LPH_CONN_IND_BIT] = state_ff.ind.conn_ind;
    stat_word[LPH_RST_IND_BIT] = state_ff.ind.rst_ind;
    stat_word[LPH_XID_IND_BIT] = state_ff.ind.xid_ind;
    stat_word[LPH_TEST_IND_BIT] = state_ff.ind.test_ind;
  end

  // Next state: register writes, then engine events, then the host command.
  // The command is applied last so that a stop always wins over a same-cycle event.
  always_comb
  begin
    nxt_state = state_ff;
    nxt_state.cmd = LPH_CMD_OUT_RST;
    nxt_state.ring_reset = 1'b0;

    // Read data stand in the cycle after the strobe only.
    nxt_state.rdata = '0;
    if (reg_rd_i)
    begin
      case (reg_addr_i)
        LPH_OFS_PRIM: nxt_state.rdata = prim_word;
        LPH_OFS_CTRL: nxt_state.rdata = ctrl_word;
        LPH_OFS_STAT: nxt_state.rdata = stat_word;
        default: nxt_state.rdata = '0;
      endcase
    end

    // Host places a code and raises pending; a new code is ignored while one is pending.
    if (wr_prim & ~state_ff.user_cmd_pending)
    begin
      nxt_state.user_cmd_code = reg_wdata_i[LPH_CMD_HI:LPH_CMD_LO];
      nxt_state.user_cmd_pending = reg_wdata_i[LPH_CMD_PEND_BIT]; // RULE_02
    end
    if (wr_ctrl)
    begin
      nxt_state.irq_output_enable = reg_wdata_i[LPH_IRQ_EN_BIT];
      nxt_state.address_filter_bypass = reg_wdata_i[LPH_BYPASS_BIT];
    end

    // Lost flag follows the pending flag down when it is cleared.
    if (ev_pend_clr)
    begin
      nxt_state.provider_event_dropped = 1'b0; // RULE_14
    end
    if (event_i.valid & ~ev_post)
    begin
      nxt_state.provider_event_dropped = 1'b1; // RULE_14
    end

    // Post an engine event and track what it says about the link.
    if (ev_post)
    begin
      nxt_state.provider_event_code = event_i.code; // RULE_17 RULE_18
      nxt_state.provider_event_reason = event_i.reason; // RULE_16
    end
    if (event_i.valid)
    begin
      case (event_i.code)
        LPH_EV_CONN_IND: nxt_state.ind.conn_ind = 1'b1;
        LPH_EV_CONN_CNF: nxt_state.phase = LPH_PH_LINKED; // RULE_17
        LPH_EV_RST_IND: nxt_state.ind.rst_ind = 1'b1;
        LPH_EV_RST_CNF: nxt_state.phase = LPH_PH_LINKED; // RULE_18
        LPH_EV_XID_IND: nxt_state.ind.xid_ind = 1'b1;
        LPH_EV_TEST_IND: nxt_state.ind.test_ind = 1'b1;
        LPH_EV_DISC_IND:
        begin
          nxt_state.phase = LPH_PH_DISC; // RULE_19
          nxt_state.ind.conn_ind = 1'b0;
          nxt_state.ind.rst_ind = 1'b0;
        end
        default: nxt_state.phase = nxt_state.phase;
      endcase
      // Events move no phase while stopped or transparent; keep the phase there.
      if ((state_ff.phase == LPH_PH_STOPPED) | (state_ff.phase == LPH_PH_TRANSP))
      begin
        nxt_state.phase = state_ff.phase;
      end
    end

    // Carry out the pending command.
    if (process_cmd)
    begin
      nxt_state.user_cmd_pending = 1'b0; // RULE_02
      if (cmd_legal)
      begin
        nxt_state.cmd.valid = 1'b1;
        nxt_state.cmd.code = state_ff.user_cmd_code;
        case (state_ff.user_cmd_code)
          LPH_CMD_STOP:
          begin
            nxt_state.phase = LPH_PH_STOPPED; // RULE_04
            nxt_state.ind.conn_ind = 1'b0;
            nxt_state.ind.rst_ind = 1'b0;
            nxt_state.ind.xid_ind = 1'b0;
            nxt_state.ind.test_ind = 1'b0;
            nxt_state.irq_output_enable = 1'b0;
          end
          LPH_CMD_START:
          begin
            nxt_state.phase = LPH_PH_DISC; // RULE_05
            nxt_state.ring_reset = 1'b1; // RULE_05
          end
          LPH_CMD_INIT: nxt_state.ind.init_done = 1'b1; // RULE_06
          LPH_CMD_TRANSP: nxt_state.phase = LPH_PH_TRANSP; // RULE_07
          LPH_CMD_CONN_REQ: nxt_state.phase = LPH_PH_CONNECTING; // RULE_09
          LPH_CMD_CONN_RSP:
          begin
            nxt_state.phase = LPH_PH_LINKED; // RULE_09
            nxt_state.ind.conn_ind = 1'b0;
          end
          LPH_CMD_RST_REQ: nxt_state.phase = LPH_PH_RESETTING; // RULE_10
          LPH_CMD_RST_RSP:
          begin
            nxt_state.phase = LPH_PH_LINKED; // RULE_10
            nxt_state.ind.rst_ind = 1'b0;
          end
          LPH_CMD_XID_RSP: nxt_state.ind.xid_ind = 1'b0; // RULE_11
          LPH_CMD_TEST_RSP: nxt_state.ind.test_ind = 1'b0; // RULE_12
          LPH_CMD_DISC_REQ:
          begin
            // An idle link gets a DM with the final bit clear instead of a disconnect.
            nxt_state.cmd.send_dm = (state_ff.phase == LPH_PH_DISC); // RULE_13
            nxt_state.phase = LPH_PH_DISC; // RULE_13
            nxt_state.ind.conn_ind = 1'b0;
            nxt_state.ind.rst_ind = 1'b0;
          end
          default: nxt_state.cmd.valid = 1'b1;
        endcase
      end
    end

    // Link-facing levels follow the next phase so they change with it.
    nxt_state.stopped = (nxt_state.phase == LPH_PH_STOPPED); // RULE_04
    nxt_state.tx_mark = (nxt_state.phase == LPH_PH_STOPPED); // RULE_04
    nxt_state.dma_halt = (nxt_state.phase == LPH_PH_STOPPED); // RULE_04
    nxt_state.tx_flags = (nxt_state.phase != LPH_PH_STOPPED); // RULE_05
    nxt_state.transparent = (nxt_state.phase == LPH_PH_TRANSP); // RULE_07
    // The update flag lags by one cycle here; the interrupt is a level, so that is harmless.
    nxt_state.irq = update_flag & nxt_state.irq_output_enable; // RULE_21
  end

  // Register the whole state.
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      state_ff <= LPH_STATE_RST;
    end
    else
    begin
      state_ff <= nxt_state;
    end
  end

  // Every output comes straight from the state register.
  assign reg_rdata_o = state_ff.rdata;
  assign cmd_o = state_ff.cmd;
  assign ring_reset_o = state_ff.ring_reset;
  assign stopped_o = state_ff.stopped;
  assign tx_mark_o = state_ff.tx_mark;
  assign tx_flags_o = state_ff.tx_flags;
  assign dma_halt_o = state_ff.dma_halt;
  assign transparent_o = state_ff.transparent;
  assign address_filter_bypass_o = state_ff.address_filter_bypass; // RULE_07
  assign irq_o = state_ff.irq;

endmodule // lph_link_primitive_handshake

/* lph_engine_model.sv */
/*
  Behavioural protocol engine beside the primitive exchange block.
  Assumes one clock, synchronous reset, and a bench that injects remote events.
*/
`timescale 1ns/1ns
module lph_engine_model
  import lph_pkg::*;
(
  input wire logic clk_i,
  input wire logic srst_i,
  input wire lph_cmd_out_t cmd_i,
  input wire lph_event_t inj_i,
  output lph_event_t event_o
);
  lph_event_t nxt_ev;
  // Answers init and requests with confirmations, a disconnect request with a disconnect indication; an injected remote event wins the cycle.
  always_comb
  begin
    nxt_ev = inj_i;
    if (cmd_i.valid && !inj_i.valid)
    begin
      case (cmd_i.code)
        LPH_CMD_INIT: nxt_ev = '{1'b1, LPH_EV_INIT_DONE, 2'h0};
        LPH_CMD_CONN_REQ: nxt_ev = '{1'b1, LPH_EV_CONN_CNF, 2'h0};
        LPH_CMD_RST_REQ: nxt_ev = '{1'b1, LPH_EV_RST_CNF, 2'h0};
        LPH_CMD_XID_REQ: nxt_ev = '{1'b1, LPH_EV_XID_CNF, 2'h0};
        LPH_CMD_TEST_REQ: nxt_ev = '{1'b1, LPH_EV_TEST_CNF, 2'h0};
        LPH_CMD_DISC_REQ: nxt_ev = '{1'b1, LPH_EV_DISC_IND, 2'h0};
        default: nxt_ev = '0;
      endcase
    end
  end
  // Events leave as one-cycle pulses, one edge after their cause.
  always_ff @(posedge clk_i)
  begin
    event_o <= srst_i ? '0 : nxt_ev;
  end
endmodule // lph_engine_model

/* lph_link_primitive_handshake_sva.sv */
/*
  Port checks for the primitive exchange block.
  Assumes it is bound to the top module and sees only its ports.
*/
`timescale 1ns/1ns
module lph_sva
  import lph_pkg::*;
(
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic [3:0] reg_addr_i,
  input wire logic [15:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire lph_cmd_out_t cmd_o,
  input wire logic ring_reset_o,
  input wire logic stopped_o,
  input wire logic tx_mark_o,
  input wire logic tx_flags_o,
  input wire logic dma_halt_o,
  input wire logic transparent_o
);
  // One clock domain, so clock and reset are given once.
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (srst_i);
  property p_stop_lvl;
    stopped_o |-> tx_mark_o && dma_halt_o && !tx_flags_o && !transparent_o;
  endproperty
  a_stop_lvl: assert property (p_stop_lvl) else $error("stopped levels wrong");
  property p_cmd_src;
    cmd_o.valid |-> $past(reg_wr_i, 2) && $past(reg_addr_i, 2) == LPH_OFS_PRIM
      && $past(reg_wdata_i[14], 2) && cmd_o.code == $past(reg_wdata_i[11:8], 2);
  endproperty
  a_cmd_src: assert property (p_cmd_src) else $error("command without host write");
  property p_stop_cmd;
    cmd_o.valid && cmd_o.code == 4'h0 |-> ##[0:2] stopped_o;
  endproperty
  a_stop_cmd: assert property (p_stop_cmd) else $error("stop not entered");
  property p_start;
    cmd_o.valid && cmd_o.code == 4'h1 |-> ring_reset_o && !stopped_o && tx_flags_o;
  endproperty
  a_start: assert property (p_start) else $error("start effects missing");
  property p_ring_src;
    ring_reset_o |-> cmd_o.valid && cmd_o.code == 4'h1;
  endproperty
  a_ring_src: assert property (p_ring_src) else $error("ring reset without start");
  property p_transp;
    transparent_o |=> transparent_o || stopped_o;
  endproperty
  a_transp: assert property (p_transp) else $error("transparent left wrongly");
  property p_dm;
    cmd_o.send_dm |-> cmd_o.valid && cmd_o.code == 4'hE;
  endproperty
  a_dm: assert property (p_dm) else $error("DM without disconnect");
  property p_bad_code;
    cmd_o.valid |-> cmd_o.code != 4'h5 && cmd_o.code != 4'hF;
  endproperty
  a_bad_code: assert property (p_bad_code) else $error("unlisted code accepted");
endmodule // lph_sva
bind lph_link_primitive_handshake lph_sva u_lph_sva (.clk_i, .srst_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i,
  .cmd_o, .ring_reset_o, .stopped_o, .tx_mark_o, .tx_flags_o, .dma_halt_o, .transparent_o);

/* test_link_primitive_handshake.sv */
/*
  Self-checking bench for the primitive exchange block with an engine model.
  Assumes the register map and the command and event timing of the block.
*/
`timescale 1ns/1ns
module test_link_primitive_handshake
  import lph_pkg::*;
;
  logic clk_i = 1'b0;
  logic srst_i = 1'b1;
  logic [3:0] reg_addr_i = 4'h0;
  logic [15:0] reg_wdata_i = 16'h0000;
  logic reg_wr_i = 1'b0;
  logic reg_rd_i = 1'b0;
  logic [15:0] reg_rdata_o;
  lph_event_t event_i;
  lph_event_t inj = '0;
  lph_cmd_out_t cmd_o;
  logic ring_reset_o, stopped_o, tx_mark_o, tx_flags_o, dma_halt_o, transparent_o, bypass, irq_o;
  int bad_count = 0;
  int tests_run = 0;
  int ncmd = 0;
  int nring = 0;
  logic [3:0] last_cmd = 4'h0;
  logic last_dm = 1'b0;
  logic [15:0] w;
  lph_link_primitive_handshake u_lph_link_primitive_handshake (.clk_i, .srst_i, .reg_addr_i, .reg_wdata_i,
    .reg_wr_i, .reg_rd_i, .reg_rdata_o, .event_i, .cmd_o, .ring_reset_o, .stopped_o, .tx_mark_o,
    .tx_flags_o, .dma_halt_o, .transparent_o, .address_filter_bypass_o(bypass), .irq_o);
  lph_engine_model u_lph_engine_model (.clk_i, .srst_i, .cmd_i(cmd_o), .inj_i(inj), .event_o(event_i));
  // Free-running 100 MHz clock.
  always #5 clk_i = ~clk_i;
  // Counts commands handed to the engine, since they last only one cycle.
  always @(posedge clk_i)
  begin
    if (cmd_o.valid === 1'b1)
    begin
      ncmd <= ncmd + 1;
      last_cmd <= cmd_o.code;
      last_dm <= cmd_o.send_dm;
    end
    if (ring_reset_o === 1'b1)
      nring <= nring + 1;
  end
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    tests_run++;
    if (g !== e)
    begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk_i);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    @(posedge clk_i);
    reg_wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a);
    @(posedge clk_i);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge clk_i);
    reg_rd_i <= 1'b0;
    #1;
    w = reg_rdata_o;
  endtask
  // Output levels packed as stopped, mark, halt, flags, transparent, bypass, irq.
  task automatic lvl(input logic [6:0] e);
    chk("levels", {9'h0, e}, {9'h0, stopped_o, tx_mark_o, dma_halt_o, tx_flags_o, transparent_o, bypass, irq_o});
  endtask
  // Issues one command; ev is the event the engine should confirm with, 0 for none.
  task automatic issue(input logic [3:0] c, input logic ok, input logic [3:0] ev);
    int n0;
    n0 = ncmd;
    wr(LPH_OFS_PRIM, {4'h4, c, 8'h00});
    tick(6);
    chk("accepted", {15'h0, ok}, {15'h0, ncmd != n0});
    if (ok)
      chk("command", {12'h0, c}, {12'h0, last_cmd});
    rd(LPH_OFS_PRIM);
    chk("conflict", {15'h0, !ok}, {15'h0, w[15]});
    chk("pending", 16'h0, {15'h0, w[14]});
    chk("event pending", {15'h0, ev != 4'h0}, {15'h0, w[6]});
    if (ev != 4'h0)
      chk("event code", {12'h0, ev}, {12'h0, w[3:0]});
    wr(LPH_OFS_PRIM, 16'h0000);
    rd(LPH_OFS_PRIM);
    chk("conflict held", {15'h0, !ok}, {15'h0, w[15]});
    wr(LPH_OFS_PRIM, 16'h8040);
    rd(LPH_OFS_PRIM);
    chk("flags cleared", 16'h0, w & 16'hC0C0);
  endtask
  // Injects a remote event and compares the low byte of the exchange word.
  task automatic post(input logic [3:0] c, input logic [1:0] r, input logic [7:0] e, input logic clr);
    @(posedge clk_i);
    inj <= '{1'b1, c, r};
    @(posedge clk_i);
    inj <= '0;
    tick(2);
    rd(LPH_OFS_PRIM);
    chk("event word", {8'h0, e}, {8'h0, w[7:0]});
    if (clr)
    begin
      wr(LPH_OFS_PRIM, 16'h0040);
      rd(LPH_OFS_PRIM);
      chk("event cleared", 16'h0, {14'h0, w[7:6]});
    end
  endtask
  task automatic t_reset;
    rd(LPH_OFS_PRIM);
    chk("prim reset", 16'h0, w);
    lvl(7'h70);
    wr(4'hF, 16'hFFFF);
    rd(4'hF);
    chk("unmapped", 16'h0, w);
    rd(LPH_OFS_CTRL);
    chk("ctrl reset", 16'h0, w);
  endtask
  task automatic t_refuse;
    issue(4'h6, 1'b0, 4'h0);
    issue(4'h5, 1'b0, 4'h0);
    issue(4'hF, 1'b0, 4'h0);
    issue(4'h4, 1'b0, 4'h0);
    issue(4'h8, 1'b0, 4'h0);
    issue(4'hA, 1'b0, 4'h0);
    issue(4'hC, 1'b0, 4'h0);
    issue(4'hE, 1'b0, 4'h0);
  endtask
  task automatic t_bringup;
    issue(4'h2, 1'b1, 4'h2);
    issue(4'h4, 1'b1, 4'h0);
    issue(4'h1, 1'b1, 4'h0);
    chk("ring resets", 16'h1, nring[15:0]);
    lvl(7'h08);
    rd(LPH_OFS_STAT);
    chk("state word", 16'h0009, w);
    issue(4'h1, 1'b0, 4'h0);
    issue(4'h2, 1'b1, 4'h2);
    issue(4'hE, 1'b1, 4'hE);
    chk("dm sent", 16'h1, {15'h0, last_dm});
    issue(4'h8, 1'b0, 4'h0);
    issue(4'h7, 1'b0, 4'h0);
    issue(4'h9, 1'b0, 4'h0);
    issue(4'hB, 1'b0, 4'h0);
    issue(4'hD, 1'b0, 4'h0);
  endtask
  task automatic t_linked;
    issue(4'h6, 1'b1, 4'h7);
    issue(4'h8, 1'b1, 4'h9);
    issue(4'hA, 1'b1, 4'hB);
    issue(4'hC, 1'b1, 4'hD);
    post(4'h8, 2'h0, 8'h48, 1'b1);
    issue(4'h9, 1'b1, 4'h0);
    post(4'hA, 2'h0, 8'h4A, 1'b1);
    issue(4'hB, 1'b1, 4'h0);
    post(4'hC, 2'h0, 8'h4C, 1'b1);
    issue(4'hD, 1'b1, 4'h0);
    post(4'h4, 2'h2, 8'h64, 1'b1);
    issue(4'h8, 1'b1, 4'h9);
    post(4'hA, 2'h0, 8'h4A, 1'b0);
    post(4'hC, 2'h0, 8'hCA, 1'b1);
    post(4'hE, 2'h3, 8'h7E, 1'b1);
    issue(4'h8, 1'b0, 4'h0);
    post(4'h6, 2'h0, 8'h46, 1'b1);
    issue(4'h7, 1'b1, 4'h0);
    lvl(7'h08);
  endtask
  task automatic t_transp_irq;
    issue(4'h0, 1'b1, 4'h0);
    lvl(7'h70);
    wr(LPH_OFS_CTRL, 16'h0003);
    issue(4'h3, 1'b1, 4'h0);
    lvl(7'h0F);
    issue(4'h1, 1'b0, 4'h0);
    wr(LPH_OFS_CTRL, 16'h0002);
    tick(3);
    lvl(7'h0E);
    wr(LPH_OFS_CTRL, 16'h000B);
    tick(3);
    lvl(7'h0E);
    rd(LPH_OFS_CTRL);
    chk("ctrl word", 16'h0003, w);
    issue(4'h0, 1'b1, 4'h0);
    lvl(7'h72);
  endtask
  task automatic complete_run;
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // Main sequence after five cycles of reset.
  initial
  begin
    repeat (5) @(posedge clk_i);
    srst_i <= 1'b0;
    tick(1);
    t_reset();
    t_refuse();
    t_bringup();
    t_linked();
    t_transp_irq();
    complete_run();
  end
  // Cuts a hang short well past the expected several hundred cycles.
  initial
  begin
    #500000;
    bad_count++;
    complete_run();
  end
endmodule // test_link_primitive_handshake
